/* File: csf_filter.sv */
// comparator sample filter with edge flags, interrupt and dma request, axi4-lite slave
`timescale 1ns/1ps
`include "csf_consts.svh"
module csf_filter #(
    parameter int CNT_W = `CSF_CNT_W,
    parameter int PER_W = `CSF_PER_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // analog side
    input wire logic rawCompareIn,
    input wire logic windowIn,
    input wire logic sampleIn,
    // dma completion from dma engine
    input wire logic dmaDone,
    // axi4-lite write
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // outputs
    output logic filteredCompareOut,
    output csf_pkg::csf_req_t req
);
    // registers
    logic [CNT_W-1:0] filterSampleCount_q, filterSampleCount_d; // filter_config_reg
    logic [3:0] ctrl_q, ctrl_d; // compare_control_reg
    logic [PER_W-1:0] samplePeriodDivider_q, samplePeriodDivider_d; // filter_period_reg
    logic risingIrqEnable_q, risingIrqEnable_d;
    logic fallingIrqEnable_q, fallingIrqEnable_d;
    logic dmaRequestEnable_q, dmaRequestEnable_d;
    logic risingEdgeFlag_q, risingEdgeFlag_d;
    logic fallingEdgeFlag_q, fallingEdgeFlag_d;
    // bus state
    logic awHave_q, awHave_d, wHave_q, wHave_d;
    logic [11:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    // pin synchronisers
    logic [1:0] rawSync_q, winSync_q, smpSync_q, dmaSync_q;
    logic smpPrev_q, dmaPrev_q;
    // datapath state
    logic winLatch_q, winLatch_d;
    logic [PER_W-1:0] divCnt_q, divCnt_d;
    logic [CNT_W-1:0] agreeCnt_q, agreeCnt_d;
    logic filtOut_q, filtOut_d;
    logic outSync_q, outSync_d, outPrev_q;
    logic irq_q, irq_d, dmaReq_q, dmaReq_d;
    csf_pkg::csf_mode_t mode;
    logic src, tick, wrFire, dmaDoneEv, riseEv, fallEv;
    logic rawPol; // synchronised raw level after the polarity select

    // address decode used by both channels
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `CSF_OFS_FILTCFG) || (a == `CSF_OFS_CTRL) || (a == `CSF_OFS_PERIOD) ||
                 (a == `CSF_OFS_STATUS);
    endfunction : mapped

    // mode decode from control fields
    always_comb begin
        logic cz, pz, c1;
        cz = (filterSampleCount_q == `CSF_CNT_ZERO);
        pz = (samplePeriodDivider_q == `CSF_PER_ZERO);
        c1 = (filterSampleCount_q == `CSF_CNT_ONE);
        if (!ctrl_q[`CSF_CTRL_EN]) begin
            mode = csf_pkg::CSF_OFF;
        end else if (ctrl_q[`CSF_CTRL_WE]) begin
            if (cz || pz) mode = csf_pkg::CSF_WIN;
            else if (c1) mode = csf_pkg::CSF_WRES;
            else mode = csf_pkg::CSF_WFILT;
        end else if (ctrl_q[`CSF_CTRL_SE]) begin
            mode = c1 || cz ? csf_pkg::CSF_SAMP : csf_pkg::CSF_FILT;
        end else if (cz || pz) begin
            mode = csf_pkg::CSF_CONT;
        end else begin
            mode = c1 ? csf_pkg::CSF_SAMP : csf_pkg::CSF_FILT;
        end
    end

    // sample source, timebase and agreement filter
    always_comb begin
        logic win, filtOn, thr;
        // polarity is applied behind the synchroniser so the pin meets two flops first
        rawPol = rawSync_q[1] ^ ctrl_q[`CSF_CTRL_INV];
        win = (mode == csf_pkg::CSF_WIN) || (mode == csf_pkg::CSF_WRES) || (mode == csf_pkg::CSF_WFILT);
        winLatch_d = win && winSync_q[1] ? rawPol : winLatch_q;
        src = win ? winLatch_q : rawPol;
        filtOn = (mode != csf_pkg::CSF_OFF) && (mode != csf_pkg::CSF_CONT) && (mode != csf_pkg::CSF_WIN);
        divCnt_d = divCnt_q;
        tick = 1'b0;
        if (!filtOn) begin
            divCnt_d = '0;
        end else if (ctrl_q[`CSF_CTRL_SE] && !win) begin
            tick = smpSync_q[1] && !smpPrev_q;
        end else if (divCnt_q >= samplePeriodDivider_q - PER_W'(1)) begin
            tick = 1'b1;
            divCnt_d = '0;
        end else begin
            divCnt_d = divCnt_q + PER_W'(1);
        end
        thr = (mode == csf_pkg::CSF_SAMP || mode == csf_pkg::CSF_WRES) ? 1'b1 :
              (agreeCnt_q + CNT_W'(1) >= filterSampleCount_q);
        agreeCnt_d = agreeCnt_q;
        filtOut_d = filtOut_q;
        if (!filtOn) begin
            agreeCnt_d = '0;
            filtOut_d = (mode == csf_pkg::CSF_OFF) ? `CSF_RST_OUT : src;
        end else if (tick) begin
            if (src == filtOut_q) begin
                agreeCnt_d = '0;
            end else if (thr) begin
                filtOut_d = src;
                agreeCnt_d = '0;
            end else begin
                agreeCnt_d = agreeCnt_q + CNT_W'(1);
            end
        end
        outSync_d = filtOut_q;
    end

    // edge flags, irq and dma request
    always_comb begin
        riseEv = outSync_q && !outPrev_q;
        fallEv = !outSync_q && outPrev_q;
        dmaDoneEv = dmaSync_q[1] && !dmaPrev_q;
        risingEdgeFlag_d = risingEdgeFlag_q;
        fallingEdgeFlag_d = fallingEdgeFlag_q;
        if (wrFire && wStrb_q[0] && awAddr_q == `CSF_OFS_STATUS) begin
            if (wData_q[`CSF_ST_CFR]) risingEdgeFlag_d = 1'b0;
            if (wData_q[`CSF_ST_CFF]) fallingEdgeFlag_d = 1'b0;
        end
        if (dmaDoneEv && dmaReq_q) begin
            risingEdgeFlag_d = 1'b0;
            fallingEdgeFlag_d = 1'b0;
        end
        if (riseEv) risingEdgeFlag_d = 1'b1;
        if (fallEv) fallingEdgeFlag_d = 1'b1;
        irq_d = !dmaRequestEnable_q && ((risingIrqEnable_q && risingEdgeFlag_q) ||
                (fallingIrqEnable_q && fallingEdgeFlag_q));
        dmaReq_d = dmaRequestEnable_q && ((risingIrqEnable_q && risingEdgeFlag_q) ||
                   (fallingIrqEnable_q && fallingEdgeFlag_q)) && !(dmaDoneEv && dmaReq_q);
    end

    // axi4-lite slave, write then read
    always_comb begin
        logic [31:0] m;
        m = '0;
        awHave_d = awHave_q;
        wHave_d = wHave_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bvalid_d = bvalid_q && !bready;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q && !rready;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        filterSampleCount_d = filterSampleCount_q;
        ctrl_d = ctrl_q;
        samplePeriodDivider_d = samplePeriodDivider_q;
        risingIrqEnable_d = risingIrqEnable_q;
        fallingIrqEnable_d = fallingIrqEnable_q;
        dmaRequestEnable_d = dmaRequestEnable_q;
        if (awvalid && awready) begin
            awHave_d = 1'b1;
            awAddr_d = awaddr;
        end
        if (wvalid && wready) begin
            wHave_d = 1'b1;
            wData_d = wdata;
            wStrb_d = wstrb;
        end
        wrFire = awHave_q && wHave_q && !bvalid_q;
        if (wrFire) begin
            awHave_d = 1'b0;
            wHave_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mapped(awAddr_q) ? 2'h0 : 2'h2;
            if (wStrb_q[0]) begin
                if (awAddr_q == `CSF_OFS_FILTCFG) begin
                    filterSampleCount_d = wData_q[CNT_W-1:0];
                end else if (awAddr_q == `CSF_OFS_CTRL) begin
                    ctrl_d = wData_q[3:0];
                end else if (awAddr_q == `CSF_OFS_PERIOD) begin
                    samplePeriodDivider_d = wData_q[PER_W-1:0];
                end else if (awAddr_q == `CSF_OFS_STATUS) begin
                    fallingIrqEnable_d = wData_q[`CSF_ST_IEF];
                    risingIrqEnable_d = wData_q[`CSF_ST_IER];
                    dmaRequestEnable_d = wData_q[`CSF_ST_DMA];
                end
            end
        end
        if (arvalid && arready) begin
            m = '0;
            if (araddr == `CSF_OFS_FILTCFG) begin
                m[CNT_W-1:0] = filterSampleCount_q;
            end else if (araddr == `CSF_OFS_CTRL) begin
                m[3:0] = ctrl_q;
            end else if (araddr == `CSF_OFS_PERIOD) begin
                m[PER_W-1:0] = samplePeriodDivider_q;
            end else if (araddr == `CSF_OFS_STATUS) begin
                m[`CSF_ST_OUT] = filtOut_q;
                m[`CSF_ST_CFF] = fallingEdgeFlag_q;
                m[`CSF_ST_CFR] = risingEdgeFlag_q;
                m[`CSF_ST_IEF] = fallingIrqEnable_q;
                m[`CSF_ST_IER] = risingIrqEnable_q;
                m[`CSF_ST_DMA] = dmaRequestEnable_q;
            end
            rvalid_d = 1'b1;
            rdata_d = m;
            rresp_d = mapped(araddr) ? 2'h0 : 2'h2;
        end
    end

    // ready terms from held state
    assign awready = !awHave_q;
    assign wready = !wHave_q;
    assign arready = !rvalid_q;

    // registering of all state
    always_ff @(posedge mclk) begin
        rawSync_q <= {rawSync_q[0], rawCompareIn};
        winSync_q <= {winSync_q[0], windowIn};
        smpSync_q <= {smpSync_q[0], sampleIn};
        dmaSync_q <= {dmaSync_q[0], dmaDone};
        if (rst) begin
            smpPrev_q <= 1'b0;
            dmaPrev_q <= 1'b0;
            filterSampleCount_q <= '0;
            ctrl_q <= '0;
            samplePeriodDivider_q <= '0;
            risingIrqEnable_q <= 1'b0;
            fallingIrqEnable_q <= 1'b0;
            dmaRequestEnable_q <= 1'b0;
            risingEdgeFlag_q <= 1'b0;
            fallingEdgeFlag_q <= 1'b0;
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= 2'h0;
            winLatch_q <= 1'b0;
            divCnt_q <= '0;
            agreeCnt_q <= '0;
            filtOut_q <= `CSF_RST_OUT;
            outSync_q <= 1'b0;
            outPrev_q <= 1'b0;
            irq_q <= 1'b0;
            dmaReq_q <= 1'b0;
        end else begin
            smpPrev_q <= smpSync_q[1];
            dmaPrev_q <= dmaSync_q[1];
            filterSampleCount_q <= filterSampleCount_d;
            ctrl_q <= ctrl_d;
            samplePeriodDivider_q <= samplePeriodDivider_d;
            risingIrqEnable_q <= risingIrqEnable_d;
            fallingIrqEnable_q <= fallingIrqEnable_d;
            dmaRequestEnable_q <= dmaRequestEnable_d;
            risingEdgeFlag_q <= risingEdgeFlag_d;
            fallingEdgeFlag_q <= fallingEdgeFlag_d;
            awHave_q <= awHave_d;
            wHave_q <= wHave_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            winLatch_q <= winLatch_d;
            divCnt_q <= divCnt_d;
            agreeCnt_q <= agreeCnt_d;
            filtOut_q <= filtOut_d;
            outSync_q <= outSync_d;
            outPrev_q <= outSync_q;
            irq_q <= irq_d;
            dmaReq_q <= dmaReq_d;
        end
    end

    // outputs straight from flip-flops
    assign filteredCompareOut = outSync_q;
    assign req = '{irq: irq_q, dmaReq: dmaReq_q};
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // checks
    AST_RISE_SETS: assert property (@(posedge mclk) disable iff (rst) riseEv |=> risingEdgeFlag_q)
        else $error("rising edge did not set flag");
    AST_FALL_SETS: assert property (@(posedge mclk) disable iff (rst) fallEv |=> fallingEdgeFlag_q)
        else $error("falling edge did not set flag");
    AST_IRQ_CAUSE: assert property (@(posedge mclk) disable iff (rst)
        irq_q |-> $past(risingIrqEnable_q && risingEdgeFlag_q || fallingIrqEnable_q && fallingEdgeFlag_q))
        else $error("irq without enabled flag");
    AST_IRQ_DROP: assert property (@(posedge mclk) disable iff (rst)
        (!risingEdgeFlag_q && !fallingEdgeFlag_q) |=> !irq_q)
        else $error("irq stayed with flags clear");
    AST_DMA_NO_IRQ: assert property (@(posedge mclk) disable iff (rst) dmaRequestEnable_q |=> !irq_q)
        else $error("irq raised while dma selected");
    AST_DMA_RAISE: assert property (@(posedge mclk) disable iff (rst)
        (dmaRequestEnable_q && risingIrqEnable_q && risingEdgeFlag_q && !dmaSync_q[1]) |=> dmaReq_q)
        else $error("dma request missing");
    AST_DISABLED_RESET: assert property (@(posedge mclk) disable iff (rst)
        (mode == csf_pkg::CSF_CONT || mode == csf_pkg::CSF_OFF) |=> agreeCnt_q == '0 && divCnt_q == '0)
        else $error("filter state not reset when disabled");
    AST_OFF_LOW: assert property (@(posedge mclk) disable iff (rst)
        (mode == csf_pkg::CSF_OFF) [*2] |=> !filteredCompareOut)
        else $error("output high while comparator off");
    AST_HOLD_NOTICK: assert property (@(posedge mclk) disable iff (rst)
        (mode == csf_pkg::CSF_FILT && !tick) |=> $stable(filtOut_q))
        else $error("filter output moved without a sample");
    AST_DIV_BOUND: assert property (@(posedge mclk) disable iff (rst)
        (mode == csf_pkg::CSF_FILT && !ctrl_q[`CSF_CTRL_SE]) |-> divCnt_q < samplePeriodDivider_q)
        else $error("divider count out of range");
endmodule : csf_filter

/* File: csf_consts.svh */
// offsets, field positions, reset values and counts of the comparator sample filter
`ifndef CSF_CONSTS_SVH
`define CSF_CONSTS_SVH
`define CSF_OFS_FILTCFG 12'h000
`define CSF_OFS_CTRL 12'h004
`define CSF_OFS_PERIOD 12'h008
`define CSF_OFS_STATUS 12'h00c
`define CSF_CTRL_EN 0
`define CSF_CTRL_INV 1
`define CSF_CTRL_WE 2
`define CSF_CTRL_SE 3
`define CSF_ST_OUT 0
`define CSF_ST_CFF 1
`define CSF_ST_CFR 2
`define CSF_ST_IEF 3
`define CSF_ST_IER 4
`define CSF_ST_DMA 6
`define CSF_CNT_W 3
`define CSF_PER_W 8
`define CSF_CNT_ONE 3'h1
`define CSF_CNT_ZERO 3'h0
`define CSF_PER_ZERO 8'h00
`define CSF_RST_OUT 1'b0
`endif

/* File: csf_pkg.sv */
// types of the comparator sample filter
package csf_pkg;
    // filter operating modes
    typedef enum logic [2:0] {
        CSF_OFF = 3'h0,
        CSF_CONT = 3'h1,
        CSF_SAMP = 3'h3,
        CSF_FILT = 3'h2,
        CSF_WIN = 3'h6,
        CSF_WRES = 3'h7,
        CSF_WFILT = 3'h5
    } csf_mode_t;
    // edge request outputs
    typedef struct packed {
        logic irq;
        logic dmaReq;
    } csf_req_t;
endpackage : csf_pkg

/* File: csf_far_model.sv */
// model of the sample strobe source and dma engine on the far side of the filter
`timescale 1ns/1ps
module csf_far_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // controls from the bench
    input wire logic strobeOn,
    input wire logic slowDone,
    // request from the filter
    input wire logic dmaReq,
    // towards the filter
    output logic sampleIn,
    output logic dmaDone
);
    int div = 0; // strobe divider, eight cycles a strobe period
    int dly = 0; // cycles since the dma request was seen
    // external sample strobe, idle low while not wanted
    always @(posedge mclk) begin
        div <= (div + 1) % 4;
        if (rst || !strobeOn) begin
            sampleIn <= 1'b0;
        end else if (div == 0) begin
            sampleIn <= !sampleIn;
        end
    end
    // dma engine: completion after a short or long transfer, held until the request drops
    always @(posedge mclk) begin
        if (rst || dmaReq !== 1'b1) begin
            dly <= 0;
            dmaDone <= 1'b0;
        end else begin
            dly <= dly + 1;
            if (dly == (slowDone ? 12 : 2)) dmaDone <= 1'b1;
        end
    end
endmodule : csf_far_model

/* File: csf_filter_tb.sv */
// self-checking bench of the comparator sample filter
`timescale 1ns/1ps
`include "csf_consts.svh"
module csf_filter_tb;
    // one table row: configuration and window/strobe beside the expected output
    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] per;
        logic [3:0] ctrl;
        logic win;
        logic strobe;
        logic exp;
    } csf_row_t;
    logic mclk = 0, rst = 1, rawCompareIn = 0, windowIn = 0, sampleIn, dmaDone;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, filteredCompareOut;
    logic [1:0] bresp, rresp, resp;
    logic strobeOn = 0, slowDone = 0;
    csf_pkg::csf_req_t req;
    int error_cnt = 0, comparisons = 0, cycles = 0;
    // modes: off, continuous, sampled, filtered, external strobe, windowed, inverted
    csf_row_t rows[12] = '{'{3'h2, 8'h01, 4'h0, 1'b1, 1'b0, 1'b0}, '{3'h0, 8'h05, 4'h1, 1'b1, 1'b0, 1'b1},
        '{3'h3, 8'h00, 4'h1, 1'b1, 1'b0, 1'b1}, '{3'h1, 8'h04, 4'h1, 1'b1, 1'b0, 1'b1},
        '{3'h5, 8'h02, 4'h1, 1'b1, 1'b0, 1'b1}, '{3'h3, 8'h00, 4'h9, 1'b1, 1'b1, 1'b1},
        '{3'h3, 8'h00, 4'h9, 1'b1, 1'b0, 1'b0}, '{3'h0, 8'h00, 4'h5, 1'b1, 1'b0, 1'b1},
        '{3'h2, 8'h00, 4'h5, 1'b0, 1'b0, 1'b0}, '{3'h1, 8'h03, 4'h5, 1'b1, 1'b0, 1'b1},
        '{3'h3, 8'h02, 4'h5, 1'b1, 1'b0, 1'b1}, '{3'h0, 8'h00, 4'h3, 1'b1, 1'b0, 1'b0}};
    // design and far side
    csf_filter i_csf_filter (.mclk(mclk), .rst(rst), .rawCompareIn(rawCompareIn), .windowIn(windowIn),
        .sampleIn(sampleIn), .dmaDone(dmaDone), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .filteredCompareOut(filteredCompareOut), .req(req));
    csf_far_model i_csf_far_model (.mclk(mclk), .rst(rst), .strobeOn(strobeOn), .slowDone(slowDone),
        .dmaReq(req.dmaReq), .sampleIn(sampleIn), .dmaDone(dmaDone));
    // 100 MHz clock
    always #5 mclk = ~mclk;
    // hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt = error_cnt + 1;
            end_of_test();
        end
    end
    // compare and report
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk
    // idle cycles
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt
    // axi4-lite write, address and data offered together
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        bit aw = 0, w = 0, b = 0;
        @(posedge mclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!b) begin
            @(posedge mclk);
            if (bvalid === 1'b1) begin b = 1; resp = bresp; end
            if (!aw && awready === 1'b1) begin aw = 1; awvalid <= 1'b0; end
            if (!w && wready === 1'b1) begin w = 1; wvalid <= 1'b0; end
        end
        bready <= 1'b0;
    endtask : axw
    // axi4-lite read
    task automatic axr(input logic [11:0] a);
        bit ar = 0, r = 0;
        @(posedge mclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!r) begin
            @(posedge mclk);
            if (ar && rvalid === 1'b1) begin r = 1; rd = rdata; resp = rresp; end
            if (!ar && arready === 1'b1) begin ar = 1; arvalid <= 1'b0; end
        end
        rready <= 1'b0;
    endtask : axr
    // wait for the dma request to reach a level, bounded
    task automatic wreq(input logic lvl, input int n);
        for (int k = 0; k < n && req.dmaReq !== lvl; k++) @(posedge mclk);
    endtask : wreq
    // verdict
    task automatic end_of_test();
        if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // main sequence
    initial begin
        wt(2);
        rst <= 1'b0;
        wt(1);
        chk("out after reset", 32'(filteredCompareOut), 32'h0);
        chk("req after reset", 32'(req), 32'h0);
        axr(12'h010);
        chk("unmapped read resp", 32'(resp), 32'h2);
        chk("unmapped read data", rd, 32'h0);
        axw(12'h010, 32'h1);
        chk("unmapped write resp", 32'(resp), 32'h2);
        // table of modes: continuous mode first, configure, then raise the raw level
        foreach (rows[i]) begin
            rawCompareIn <= 1'b0; windowIn <= 1'b1; strobeOn <= rows[i].strobe;
            axw(`CSF_OFS_PERIOD, 32'h0);
            axw(`CSF_OFS_CTRL, 32'h1);
            wt(10);
            windowIn <= rows[i].win;
            axw(`CSF_OFS_FILTCFG, 32'(rows[i].cnt));
            axw(`CSF_OFS_PERIOD, 32'(rows[i].per));
            axw(`CSF_OFS_CTRL, 32'(rows[i].ctrl));
            wt(30);
            rawCompareIn <= 1'b1;
            wt(60);
            chk($sformatf("row %0d out", i), 32'(filteredCompareOut), 32'(rows[i].exp));
        end
        // noisy rise with count 4, divider 3: disagreeing sample restarts the count
        strobeOn <= 1'b0; rawCompareIn <= 1'b0; windowIn <= 1'b1;
        axw(`CSF_OFS_PERIOD, 32'h0);
        axw(`CSF_OFS_CTRL, 32'h1);
        axw(`CSF_OFS_FILTCFG, 32'h4);
        axw(`CSF_OFS_PERIOD, 32'h3);
        wt(30);
        rawCompareIn <= 1'b1; wt(6);
        rawCompareIn <= 1'b0; wt(3);
        rawCompareIn <= 1'b1; wt(10);
        chk("restarted latency", 32'(filteredCompareOut), 32'h0);
        wt(10);
        chk("bounded latency", 32'(filteredCompareOut), 32'h1);
        // continuous mode for the edge flags
        rawCompareIn <= 1'b0;
        axw(`CSF_OFS_PERIOD, 32'h0);
        axw(`CSF_OFS_FILTCFG, 32'h0);
        wt(10);
        axw(`CSF_OFS_STATUS, 32'h16);
        rawCompareIn <= 1'b1; wt(10);
        chk("rising irq", 32'(req.irq), 32'h1);
        axr(`CSF_OFS_STATUS);
        chk("rising flag", 32'(rd[2:1]), 32'h2);
        axw(`CSF_OFS_STATUS, 32'h14); wt(3);
        chk("rising irq cleared", 32'(req.irq), 32'h0);
        axw(`CSF_OFS_STATUS, 32'h08);
        rawCompareIn <= 1'b0; wt(10);
        chk("falling irq", 32'(req.irq), 32'h1);
        axw(`CSF_OFS_STATUS, 32'h0a); wt(3);
        chk("falling irq cleared", 32'(req.irq), 32'h0);
        rawCompareIn <= 1'b1; wt(10);
        chk("masked rising irq", 32'(req.irq), 32'h0);
        axr(`CSF_OFS_STATUS);
        chk("sticky rising flag", 32'(rd[2]), 32'h1);
        // dma in place of the interrupt, prompt then slow completion
        axw(`CSF_OFS_STATUS, 32'h56);
        for (int n = 0; n < 2; n++) begin
            slowDone <= n[0];
            rawCompareIn <= 1'b0; wt(8);
            rawCompareIn <= 1'b1;
            wreq(1'b1, 20);
            chk("dma request", 32'(req), 32'h1);
            wreq(1'b0, 40);
            chk("dma request dropped", 32'(req.dmaReq), 32'h0);
            axr(`CSF_OFS_STATUS);
            chk("flag cleared by dma", 32'(rd[2]), 32'h0);
        end
        end_of_test();
    end
endmodule : csf_filter_tb
